//--- core/lisc_pkg.sv
// package for the legacy index base and system control register block
// assumes a single clock, the same one that carries configuration cycles
package lisc_pkg;

   // ********************************************************************
   // register offsets and reset values
   // ********************************************************************
   localparam logic [7:0] LISC_OFS_LEGACY_BASE = 8'h44;
   localparam logic [7:0] LISC_OFS_SYS_CTRL = 8'h80;
   localparam logic [31:0] LISC_RST_LEGACY_BASE = 32'h00000001;
   localparam logic [31:0] LISC_RST_SYS_CTRL = 32'h00449060;

   // ********************************************************************
   // system control field positions (upper byte only)
   // ********************************************************************
   localparam int LISC_B_STEP_LO = 30;
   localparam int LISC_B_MERGE = 29;
   localparam int LISC_B_RSVD28 = 28;
   localparam int LISC_B_CLK_SEL = 27;
   localparam int LISC_B_ROUTE = 26;
   localparam int LISC_B_SMI_FLAG = 25;
   localparam int LISC_B_SMI_EN = 24;
   localparam int LISC_LOW_BITS = 24;

   // ********************************************************************
   // legacy port layout
   // ********************************************************************
   localparam int LISC_B_BASE_RO = 0;
   localparam logic LISC_PORT_INDEX = 1'b0;
   localparam logic LISC_PORT_DATA = 1'b1;
   localparam int LISC_NFUNC = 2;
   localparam int LISC_NSLOT = 4;

   // configuration cycle request, one per clock
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic        func;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } lisc_cfg_req_t;

   // host i/o cycle request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } lisc_io_req_t;

endpackage

//--- core/lisc_slot_map.sv
// places the two function interrupts on the four serialized irq slots
// assumes combinational use; the caller registers the result
`timescale 1ns/1ps
module lisc_slot_map (
   // function interrupt levels and setup
   input wire logic [1:0] i_func_irq,
   input wire logic i_merge,
   input wire logic [1:0] i_step,
   // slot levels A..D in bits 0..3
   output logic [lisc_pkg::LISC_NSLOT-1:0] o_slots
);
   import lisc_pkg::*;

   logic irq_first;
   logic irq_second;
   logic [1:0] slot_second;

   always_comb begin
      // merged pair rides only on the first slot, still stepped
      irq_first = i_merge ? (i_func_irq[0] | i_func_irq[1]) : i_func_irq[0];
      irq_second = i_merge ? 1'b0 : i_func_irq[1];
      slot_second = i_step + 2'h1;
      o_slots = '0;
      o_slots[i_step] = irq_first;
      o_slots[slot_second] = o_slots[slot_second] | irq_second;
   end

endmodule

//--- core/lisc_regs.sv
// legacy index/data base register and system control upper byte
// assumes config and i/o cycles arrive as one-cycle strobes on i_sys_clk,
// and socket power write strobes come from the compat register file
//
// Notes on behaviour
// - i/o at base is the index port, base plus one the data port.
// - base sits on any word boundary; bit 0 reads 1, ignores writes.
// - one base register at 44h, shared by both functions, resets 1.
// - 32-bit system control at 80h per function, resets 0044_9060h.
// - global control bits except route accept writes only through function 0; route takes writes from either function.
// - step field moves the two function irqs across slots A..D.
// - merge bit joins both irqs onto the first one, still steppable.
// - bit 28 reads zero and ignores writes.
// - clock select 0 uses external switch clock, 1 internal, driven out.
// - socket power write raises irq 2 or card status change by route bit.
// - socket smi flag sets on enabled power write; write 1 clears.
// - with smi enable set, a socket power write raises an smi; writes from both sockets in one cycle share one smi.
`timescale 1ns/1ps
module lisc_regs (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // configuration cycles
   input wire lisc_pkg::lisc_cfg_req_t i_cfg,
   output logic o_cfg_ack,
   output logic [31:0] o_cfg_rdata,
   // host i/o cycles to the legacy ports
   input wire lisc_pkg::lisc_io_req_t i_io,
   output logic o_io_ack,
   output logic [7:0] o_io_rdata,
   // compat register file side
   output logic [7:0] o_compat_index,
   output logic o_compat_wr,
   output logic o_compat_rd,
   output logic [7:0] o_compat_wdata,
   input wire logic [7:0] i_compat_rdata,
   input wire logic [1:0] i_sock_pwr_wr,
   // interrupt inputs and outputs
   input wire logic [1:0] i_func_irq,
   output logic [lisc_pkg::LISC_NSLOT-1:0] o_serial_slots,
   output logic o_irq2,
   output logic [1:0] o_card_status_change_irq,
   output logic o_smi,
   // power switch clock source
   output logic o_switch_clock_source_sel,
   output logic o_switch_clock_oe
);
   import lisc_pkg::*;

   // ********************************************************************
   // register state
   // ********************************************************************
   logic [31:0] legacy_index_port_base, next_legacy_index_port_base;
   logic [1:0] serial_irq_slot_step, next_serial_irq_slot_step;
   logic function_irq_merge, next_function_irq_merge;
   logic switch_clock_source_sel, next_switch_clock_source_sel;
   logic power_change_irq_route, next_power_change_irq_route;
   logic power_write_smi_enable, next_power_write_smi_enable;
   logic [1:0] power_write_smi_flag, next_power_write_smi_flag;
   logic [7:0] compat_index, next_compat_index;

   // ********************************************************************
   // access decode
   // ********************************************************************
   logic cfg_wr_base;
   logic cfg_wr_ctrl;
   logic io_hit;
   logic io_port;
   logic [31:0] ctrl_view;
   logic [lisc_pkg::LISC_NSLOT-1:0] slots;

   function automatic logic [31:0] sys_ctrl_read(input logic f);
      logic [31:0] v;
      v = '0;
      v[LISC_LOW_BITS-1:0] = LISC_RST_SYS_CTRL[LISC_LOW_BITS-1:0];
      v[LISC_B_STEP_LO+1:LISC_B_STEP_LO] = serial_irq_slot_step;
      v[LISC_B_MERGE] = function_irq_merge;
      v[LISC_B_RSVD28] = 1'b0;
      v[LISC_B_CLK_SEL] = switch_clock_source_sel;
      v[LISC_B_ROUTE] = power_change_irq_route;
      v[LISC_B_SMI_FLAG] = power_write_smi_flag[f];
      v[LISC_B_SMI_EN] = power_write_smi_enable;
      return v;
   endfunction

   always_comb begin
      cfg_wr_base = i_cfg.wr && (i_cfg.addr == LISC_OFS_LEGACY_BASE);
      cfg_wr_ctrl = i_cfg.wr && (i_cfg.addr == LISC_OFS_SYS_CTRL);
      // word aligned pair: bit 0 of the address picks the port
      io_hit = (i_io.wr || i_io.rd) &&
               (i_io.addr[31:1] == legacy_index_port_base[31:1]);
      io_port = i_io.addr[0];
      ctrl_view = sys_ctrl_read(i_cfg.func);
   end

   lisc_slot_map u_slot_map (
      .i_func_irq(i_func_irq),
      .i_merge(function_irq_merge),
      .i_step(serial_irq_slot_step),
      .o_slots(slots)
   );

   // ********************************************************************
   // next state of the registers
   // ********************************************************************
   always_comb begin
      next_legacy_index_port_base = legacy_index_port_base;
      next_serial_irq_slot_step = serial_irq_slot_step;
      next_function_irq_merge = function_irq_merge;
      next_switch_clock_source_sel = switch_clock_source_sel;
      next_power_change_irq_route = power_change_irq_route;
      next_power_write_smi_enable = power_write_smi_enable;
      next_power_write_smi_flag = power_write_smi_flag;
      next_compat_index = compat_index;
      // shared by both functions, so no function check here
      if (cfg_wr_base) begin
         for (int b = 0; b < 4; b++) begin
            if (i_cfg.be[b]) begin
               next_legacy_index_port_base[b*8 +: 8] = i_cfg.wdata[b*8 +: 8];
            end
         end
         next_legacy_index_port_base[LISC_B_BASE_RO] = 1'b1;
      end
      if (cfg_wr_ctrl && i_cfg.be[3]) begin
         if (i_cfg.func == 1'b0) begin
            next_serial_irq_slot_step =
               i_cfg.wdata[LISC_B_STEP_LO +: 2];
            next_function_irq_merge = i_cfg.wdata[LISC_B_MERGE];
            next_switch_clock_source_sel =
               i_cfg.wdata[LISC_B_CLK_SEL];
            next_power_write_smi_enable = i_cfg.wdata[LISC_B_SMI_EN];
         end
         next_power_change_irq_route = i_cfg.wdata[LISC_B_ROUTE];
         if (i_cfg.wdata[LISC_B_SMI_FLAG]) begin
            next_power_write_smi_flag[i_cfg.func] = 1'b0;
         end
      end
      // set after clear: a power write in the clearing cycle is kept
      for (int f = 0; f < LISC_NFUNC; f++) begin
         if (power_write_smi_enable && i_sock_pwr_wr[f]) begin
            next_power_write_smi_flag[f] = 1'b1;
         end
      end
      if (io_hit && i_io.wr && io_port == LISC_PORT_INDEX) begin
         next_compat_index = i_io.wdata;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         legacy_index_port_base <= LISC_RST_LEGACY_BASE;
         serial_irq_slot_step <= LISC_RST_SYS_CTRL[LISC_B_STEP_LO +: 2];
         function_irq_merge <= LISC_RST_SYS_CTRL[LISC_B_MERGE];
         switch_clock_source_sel <= LISC_RST_SYS_CTRL[LISC_B_CLK_SEL];
         power_change_irq_route <= LISC_RST_SYS_CTRL[LISC_B_ROUTE];
         power_write_smi_enable <= LISC_RST_SYS_CTRL[LISC_B_SMI_EN];
         power_write_smi_flag <= '0;
         compat_index <= '0;
      end else begin
         legacy_index_port_base <= next_legacy_index_port_base;
         serial_irq_slot_step <= next_serial_irq_slot_step;
         function_irq_merge <= next_function_irq_merge;
         switch_clock_source_sel <= next_switch_clock_source_sel;
         power_change_irq_route <= next_power_change_irq_route;
         power_write_smi_enable <= next_power_write_smi_enable;
         power_write_smi_flag <= next_power_write_smi_flag;
         compat_index <= next_compat_index;
      end
   end

   // ********************************************************************
   // registered outputs
   // ********************************************************************
   logic next_cfg_ack;
   logic [31:0] next_cfg_rdata;
   logic next_io_ack;
   logic [7:0] next_io_rdata;
   logic next_compat_wr;
   logic next_compat_rd;
   logic [7:0] next_compat_wdata;
   logic next_irq2;
   logic [1:0] next_csc;
   logic next_smi;

   always_comb begin
      next_cfg_ack = i_cfg.wr || i_cfg.rd;
      next_cfg_rdata = o_cfg_rdata;
      if (i_cfg.rd) begin
         unique case (i_cfg.addr)
            LISC_OFS_LEGACY_BASE: next_cfg_rdata = legacy_index_port_base;
            LISC_OFS_SYS_CTRL: next_cfg_rdata = ctrl_view;
            default: next_cfg_rdata = '0;
         endcase
      end
      next_io_ack = io_hit;
      next_io_rdata = o_io_rdata;
      next_compat_wr = io_hit && i_io.wr && io_port == LISC_PORT_DATA;
      next_compat_rd = io_hit && i_io.rd && io_port == LISC_PORT_DATA;
      next_compat_wdata = next_compat_wr ? i_io.wdata : o_compat_wdata;
      if (io_hit && i_io.rd) begin
         // compat file reads combinationally from the held index
         next_io_rdata = (io_port == LISC_PORT_INDEX) ? compat_index
                                                      : i_compat_rdata;
      end
      next_irq2 = 1'b0;
      next_csc = '0;
      for (int f = 0; f < LISC_NFUNC; f++) begin
         if (i_sock_pwr_wr[f]) begin
            if (power_change_irq_route) begin
               next_csc[f] = 1'b1;
            end else begin
               next_irq2 = 1'b1;
            end
         end
      end
      next_smi = power_write_smi_enable && (|i_sock_pwr_wr);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_cfg_ack <= 1'b0;
         o_cfg_rdata <= '0;
         o_io_ack <= 1'b0;
         o_io_rdata <= '0;
         o_compat_index <= '0;
         o_compat_wr <= 1'b0;
         o_compat_rd <= 1'b0;
         o_compat_wdata <= '0;
         o_serial_slots <= '0;
         o_irq2 <= 1'b0;
         o_card_status_change_irq <= '0;
         o_smi <= 1'b0;
         o_switch_clock_source_sel <= 1'b0;
         o_switch_clock_oe <= 1'b0;
      end else begin
         o_cfg_ack <= next_cfg_ack;
         o_cfg_rdata <= next_cfg_rdata;
         o_io_ack <= next_io_ack;
         o_io_rdata <= next_io_rdata;
         o_compat_index <= next_compat_index;
         o_compat_wr <= next_compat_wr;
         o_compat_rd <= next_compat_rd;
         o_compat_wdata <= next_compat_wdata;
         o_serial_slots <= slots;
         o_irq2 <= next_irq2;
         o_card_status_change_irq <= next_csc;
         o_smi <= next_smi;
         // internal source also drives the clock pin out
         o_switch_clock_source_sel <= switch_clock_source_sel;
         o_switch_clock_oe <= switch_clock_source_sel;
      end
   end

endmodule

//--- sim/lisc_regs_asserts.sv
// checker for the legacy base and system control register block
// assumes one clock domain, reset active low, bound to lisc_regs
`timescale 1ns/1ps
module lisc_regs_asserts (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // bus sides
   input wire lisc_pkg::lisc_cfg_req_t i_cfg,
   input wire logic o_cfg_ack,
   input wire logic [31:0] o_cfg_rdata,
   input wire lisc_pkg::lisc_io_req_t i_io,
   input wire logic o_io_ack,
   input wire logic [7:0] o_compat_index,
   input wire logic o_compat_rd,
   // events and levels
   input wire logic [1:0] i_sock_pwr_wr,
   input wire logic [1:0] i_func_irq,
   input wire logic [lisc_pkg::LISC_NSLOT-1:0] o_serial_slots,
   input wire logic o_irq2,
   input wire logic [1:0] o_card_status_change_irq,
   input wire logic o_smi,
   input wire logic o_switch_clock_source_sel,
   input wire logic o_switch_clock_oe
);
   import lisc_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   // ****************************
   // sequences and properties
   // ****************************
   sequence s_rd_base;
      i_cfg.rd && i_cfg.addr == LISC_OFS_LEGACY_BASE;
   endsequence
   sequence s_rd_ctrl;
      i_cfg.rd && i_cfg.addr == LISC_OFS_SYS_CTRL;
   endsequence
   sequence s_idx_wr;
      i_io.wr && !i_io.addr[0] ##1 o_io_ack;
   endsequence
   sequence s_wr_glob;
      i_cfg.wr && !i_cfg.func && i_cfg.be[3] &&
         i_cfg.addr == LISC_OFS_SYS_CTRL;
   endsequence
   // select lands in the register, then in the output flop
   property p_clk_sel;
      s_wr_glob |-> ##2
         o_switch_clock_source_sel == $past(i_cfg.wdata[LISC_B_CLK_SEL], 2);
   endproperty
   property p_base_ro;
      s_rd_base |=> o_cfg_ack && o_cfg_rdata[LISC_B_BASE_RO];
   endproperty
   property p_ctrl_low;
      s_rd_ctrl |=> o_cfg_ack && o_cfg_rdata[23:0] == 24'h449060;
   endproperty
   property p_rsvd28;
      s_rd_ctrl |=> !o_cfg_rdata[LISC_B_RSVD28];
   endproperty
   property p_index;
      s_idx_wr |-> o_compat_index == $past(i_io.wdata);
   endproperty
   property p_io_ack;
      o_io_ack |-> $past(i_io.wr || i_io.rd);
   endproperty
   property p_compat_rd;
      o_compat_rd |-> o_io_ack && $past(i_io.rd && i_io.addr[0]);
   endproperty
   property p_route;
      |i_sock_pwr_wr |=> o_irq2 ^ (|o_card_status_change_irq);
   endproperty
   property p_smi;
      o_smi |-> $past(|i_sock_pwr_wr);
   endproperty
   property p_clk_oe;
      o_switch_clock_oe == o_switch_clock_source_sel;
   endproperty
   property p_slots_idle;
      i_func_irq == 2'b00 |=> o_serial_slots == 4'h0;
   endproperty
   a_base_ro: assert property (p_base_ro)
      else $error("base bit0");
   a_ctrl_low: assert property (p_ctrl_low)
      else $error("ctrl low");
   a_rsvd28: assert property (p_rsvd28)
      else $error("bit 28 set");
   a_index: assert property (p_index)
      else $error("index latch");
   a_io_ack: assert property (p_io_ack)
      else $error("stray io ack");
   a_compat_rd: assert property (p_compat_rd)
      else $error("data rd");
   a_route: assert property (p_route)
      else $error("power route");
   a_smi: assert property (p_smi)
      else $error("stray smi");
   a_clk_oe: assert property (p_clk_oe)
      else $error("clock oe");
   a_clk_sel: assert property (p_clk_sel)
      else $error("clock select");
   a_slots_idle: assert property (p_slots_idle)
      else $error("slots");
endmodule

bind lisc_regs lisc_regs_asserts u_asserts (.i_sys_clk(i_sys_clk),
   .i_rst_b(i_rst_b), .i_cfg(i_cfg), .o_cfg_ack(o_cfg_ack),
   .o_cfg_rdata(o_cfg_rdata), .i_io(i_io), .o_io_ack(o_io_ack),
   .o_compat_index(o_compat_index), .o_compat_rd(o_compat_rd),
   .i_sock_pwr_wr(i_sock_pwr_wr), .i_func_irq(i_func_irq),
   .o_serial_slots(o_serial_slots), .o_irq2(o_irq2),
   .o_card_status_change_irq(o_card_status_change_irq), .o_smi(o_smi),
   .o_switch_clock_source_sel(o_switch_clock_source_sel),
   .o_switch_clock_oe(o_switch_clock_oe));

//--- sim/lisc_compat_model.sv
// model of the compat register file behind the data port
// assumes the index and strobe outputs of lisc_regs, one clock
`timescale 1ns/1ps
module lisc_compat_model (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // block side
   input wire logic [7:0] i_index,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata,
   output logic [1:0] o_pwr_wr
);
   logic [7:0] mem [256];
   // socket power control sits at 02h and 42h
   assign o_rdata = mem[i_index];
   always @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_pwr_wr <= 2'h0;
      end else begin
         o_pwr_wr <= {i_wr && i_index == 8'h42, i_wr && i_index == 8'h02};
         if (i_wr) begin
            mem[i_index] <= i_wdata;
         end
      end
   end
endmodule

//--- sim/lisc_regs_bench.sv
// self-checking bench for lisc_regs with a compat file model
// assumes the checker is bound in by its own file
`timescale 1ns/1ps
module lisc_regs_bench;
   import lisc_pkg::*;
   localparam logic [31:0] BASE = 32'h00000300;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   lisc_cfg_req_t cfg = '0;
   lisc_io_req_t io = '0;
   logic [1:0] func_irq = 2'h0;
   logic cfg_ack, io_ack, cwr, crd, irq2, smi, sel, oe;
   logic [31:0] cfg_rdata;
   logic [7:0] io_rdata, cidx, cwdata, crdata;
   logic [1:0] pwr_wr, card_status_change_irq;
   logic [3:0] slots;
   int failures = 0;
   int samples_checked = 0;
   int n_smi = 0, n_irq2 = 0, n_csc = 0;
   always #50 sys_clk = ~sys_clk;
   lisc_regs DUT (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_cfg(cfg),
      .o_cfg_ack(cfg_ack), .o_cfg_rdata(cfg_rdata), .i_io(io),
      .o_io_ack(io_ack), .o_io_rdata(io_rdata), .o_compat_index(cidx),
      .o_compat_wr(cwr), .o_compat_rd(crd), .o_compat_wdata(cwdata),
      .i_compat_rdata(crdata), .i_sock_pwr_wr(pwr_wr),
      .i_func_irq(func_irq), .o_serial_slots(slots), .o_irq2(irq2),
      .o_card_status_change_irq(card_status_change_irq), .o_smi(smi),
      .o_switch_clock_source_sel(sel), .o_switch_clock_oe(oe));
   lisc_compat_model u_model (.i_sys_clk(sys_clk), .i_rst_b(rst_b),
      .i_index(cidx), .i_wr(cwr), .i_wdata(cwdata), .o_rdata(crdata),
      .o_pwr_wr(pwr_wr));
   // event pulses last one cycle, so count them as they pass
   always @(posedge sys_clk) begin
      n_smi <= n_smi + ((smi === 1'b1) ? 1 : 0);
      n_irq2 <= n_irq2 + ((irq2 === 1'b1) ? 1 : 0);
      // socket 1 counts sixteen so a swapped socket shows up
      n_csc <= n_csc + ((card_status_change_irq[0] === 1'b1) ? 1 : 0) +
         ((card_status_change_irq[1] === 1'b1) ? 16 : 0);
   end
   // ****************************
   // access tasks
   // ****************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cfg_op(input logic w, input logic f, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] d);
      @(negedge sys_clk);
      cfg = '{wr: w, rd: !w, func: f, addr: a, be: be, wdata: d};
      @(negedge sys_clk);
      cfg = '0;
      check(32'(cfg_ack), 32'h1);
      if (!w) check(cfg_rdata, d);
   endtask
   task automatic io_op(input logic w, input logic [31:0] a,
      input logic [7:0] d, input logic ack);
      @(negedge sys_clk);
      io = '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge sys_clk);
      io = '0;
      check(32'(io_ack), 32'(ack));
      check(32'({cwr, crd}), 32'({w, !w} & {2{ack && a[0]}}));
      if (!w) check(32'(io_rdata), 32'(d));
   endtask
   task automatic irq_chk(input logic [1:0] irq, input int exp);
      func_irq = irq;
      @(negedge sys_clk);
      check(32'(slots), 32'(exp));
   endtask
   task automatic end_of_test;
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ****************************
   // tests
   // ****************************
   initial begin
      repeat (5) @(negedge sys_clk);
      rst_b = 1'b1;
      check(32'({sel, oe}), 32'h0);
      cfg_op(1'b0, 1'b0, LISC_OFS_LEGACY_BASE, 4'h0, 32'h1);
      cfg_op(1'b0, 1'b1, LISC_OFS_SYS_CTRL, 4'h0, 32'h00449060);
      cfg_op(1'b1, 1'b0, LISC_OFS_LEGACY_BASE, 4'hf, ~32'h1);
      cfg_op(1'b0, 1'b1, LISC_OFS_LEGACY_BASE, 4'h0, ~32'h0);
      cfg_op(1'b1, 1'b1, LISC_OFS_LEGACY_BASE, 4'hf, BASE);
      cfg_op(1'b0, 1'b0, LISC_OFS_LEGACY_BASE, 4'h0, 32'h301);
      cfg_op(1'b1, 1'b1, LISC_OFS_SYS_CTRL, 4'hf, 32'hff000000);
      cfg_op(1'b0, 1'b0, LISC_OFS_SYS_CTRL, 4'h0, 32'h04449060);
      // host has set terminal 3 to serialized irq before merging
      for (int s = 0; s < 4; s++) begin
         cfg_op(1'b1, 1'b0, LISC_OFS_SYS_CTRL, 4'h8,
            32'(s) << 30);
         irq_chk(2'b01, 1 << s);
         irq_chk(2'b10, 1 << ((s + 1) % 4));
         cfg_op(1'b1, 1'b0, LISC_OFS_SYS_CTRL, 4'h8,
            32'(s * 2 + 1) << 29);
         irq_chk(2'b11, 1 << s);
         irq_chk(2'b10, 1 << s);
         irq_chk(2'b00, 0);
      end
      cfg_op(1'b1, 1'b0, LISC_OFS_SYS_CTRL, 4'h8, 32'hf9000000);
      cfg_op(1'b0, 1'b1, LISC_OFS_SYS_CTRL, 4'h0, 32'he9449060);
      check(32'({sel, oe}), 32'h3);
      io_op(1'b1, BASE, 8'h02, 1'b1);
      check(32'(cidx), 32'h02);
      io_op(1'b1, BASE + 32'h1, 8'h5a, 1'b1);
      io_op(1'b1, BASE + 32'h2, 8'h40, 1'b0);
      io_op(1'b0, BASE + 32'h1, 8'h5a, 1'b1);
      io_op(1'b0, BASE, 8'h02, 1'b1);
      check({n_smi[7:0], n_irq2[7:0], n_csc[15:0]}, 32'h01010000);
      cfg_op(1'b0, 1'b0, LISC_OFS_SYS_CTRL, 4'h0, 32'heb449060);
      cfg_op(1'b0, 1'b1, LISC_OFS_SYS_CTRL, 4'h0, 32'he9449060);
      cfg_op(1'b1, 1'b0, LISC_OFS_SYS_CTRL, 4'h8, 32'heb000000);
      cfg_op(1'b0, 1'b0, LISC_OFS_SYS_CTRL, 4'h0, 32'he9449060);
      cfg_op(1'b1, 1'b0, LISC_OFS_SYS_CTRL, 4'h8, 32'hec000000);
      io_op(1'b1, BASE, 8'h42, 1'b1);
      io_op(1'b1, BASE + 32'h1, 8'h11, 1'b1);
      repeat (3) @(negedge sys_clk);
      check({n_smi[7:0], n_irq2[7:0], n_csc[15:0]}, 32'h01010010);
      cfg_op(1'b0, 1'b1, LISC_OFS_SYS_CTRL, 4'h0, 32'hec449060);
      // mid-run reset must bring every written bit back
      rst_b = 1'b0;
      @(negedge sys_clk);
      rst_b = 1'b1;
      check(32'({sel, oe}), 32'h0);
      cfg_op(1'b0, 1'b1, LISC_OFS_LEGACY_BASE, 4'h0, 32'h1);
      cfg_op(1'b0, 1'b0, LISC_OFS_SYS_CTRL, 4'h0, 32'h00449060);
      end_of_test;
   end
   // tests need under a hundred cycles; thirty times that means a hang
   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      end_of_test;
   end
endmodule
